/* File: lmc_pkg.sv */
// constants, types and carriers for the transceiver mode controller
//
// Behaviour
// - txd low makes bus dominant, high recessive
// - txd high over 10 us re-enables driver
// - enable high keeps normal mode
// - txd high plus enable fall: silent
// - txd low plus enable fall: sleep
package lmc_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ          = 20_000_000;   // ref_clk rate
	localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
	// longest time txd may stay low before the device cuts the driver
	localparam int DOM_TIMEOUT_US  = 6000;
	localparam int DOM_CYC         = DOM_TIMEOUT_US * CYC_PER_US;
	// least high time that re-arms the driver; strictly more than 10 us
	localparam int RECOVER_US      = 10;
	localparam int RECOVER_CYC     = RECOVER_US * CYC_PER_US + 1;
	// txd level set up ahead of the enable fall (mode select window)
	localparam int SETUP_US        = 10;
	localparam int SETUP_CYC       = SETUP_US * CYC_PER_US;
	// bit time for 20 kBaud
	localparam int BAUD_RATE       = 20_000;
	localparam int BAUD_CYC        = CLK_HZ / BAUD_RATE;

	////////////////////////////////////////////////////////////////////////
	// field widths and framing
	localparam int DOM_W           = 17;          // holds DOM_CYC
	localparam int GUARD_W         = 8;           // holds RECOVER_CYC
	localparam int SETUP_W         = 8;           // holds SETUP_CYC
	localparam int BAUD_W          = 16;          // holds BAUD_CYC
	localparam int DATA_W          = 8;           // one byte per word
	localparam int FRAME_BITS      = 9;           // 8 data + stop
	localparam int FIFO_DEPTH      = 8;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0]
	{
		LMC_MODE_FAILSAFE = 2'h0,
		LMC_MODE_NORMAL   = 2'h1,
		LMC_MODE_SILENT   = 2'h2,
		LMC_MODE_SLEEP    = 2'h3
	} lmc_mode_t;

	// gray along fail-safe -> normal -> setup -> low power
	typedef enum logic [1:0]
	{
		LMC_ST_FAILSAFE = 2'h0,
		LMC_ST_NORMAL   = 2'h1,
		LMC_ST_SETUP    = 2'h3,
		LMC_ST_LOWPWR   = 2'h2
	} lmc_state_t;

	// pins driven toward the transceiver
	typedef struct packed
	{
		logic enable;     // high: normal mode
		logic txd;        // low: dominant bus
	} lmc_pins_t;

	// host-side status
	typedef struct packed
	{
		lmc_mode_t mode;  // mode the device is believed to be in
		logic      in_reset;  // undervoltage reset seen low
		logic      wake;      // remote wake-up seen
		logic      rx_bit;    // registered bus level
	} lmc_status_t;

endpackage

/* File: lmc_fifo.sv */
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module lmc_fifo
	import lmc_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// draining side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// whole state in one word
	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage entries
		logic [AW-1:0]               wp;    // write index
		logic [AW-1:0]               rp;    // read index
		logic [CW-1:0]               cnt;   // words held
		logic                        can_push;  // registered not-full
		logic                        has_data;  // registered not-empty
	} fifo_st_t;

	fifo_st_t s;        // current state
	fifo_st_t next_s;   // next state
	logic     push;     // word accepted
	logic     pop;      // word removed

	////////////////////////////////////////////////////////////////////////
	// ports straight from the state
	assign in_ready  = s.can_push;
	assign out_valid = s.has_data;
	assign out_data  = s.mem[s.rp];

	////////////////////////////////////////////////////////////////////////
	// next state; flags come from the next count so they stay registered
	always_comb
	begin
		next_s = s;
		push   = in_valid && s.can_push;
		pop    = out_ready && s.has_data;
		// write at the tail
		if (push)
		begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
		end
		// advance the head
		if (pop)
			next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
		// count follows both
		if (push && !pop)
			next_s.cnt = s.cnt + CW'(1);
		else if (pop && !push)
			next_s.cnt = s.cnt - CW'(1);
		next_s.can_push = (next_s.cnt != CW'(DEPTH));
		next_s.has_data = (next_s.cnt != '0);
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s          <= '0;
			s.can_push <= 1'b1;
		end
		else
			s <= next_s;
	end

endmodule

/* File: lmc_host.sv */
// host controller driving the transceiver's enable and transmit pins
`timescale 1ns/1ps
module lmc_host
	import lmc_pkg::*;
#(
	parameter int DOM_LIMIT = DOM_CYC,     // host-side dominant cut-off
	parameter int BIT_CYC   = BAUD_CYC     // cycles per bus bit
)
(
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               reset_n,
	// byte stream to send
	input  wire logic [DATA_W-1:0]  tx_data,
	input  wire logic               tx_valid,
	output logic                    tx_ready,
	// mode requests
	input  wire logic               mode_req,
	input  wire lmc_mode_t          mode_sel,
	// status toward the user
	output lmc_status_t             status,
	output logic                    tx_busy,
	// transceiver pins
	output lmc_pins_t               pins,
	input  wire logic               rxd,
	input  wire logic               undervoltage_reset_n
);

	// whole state in one word
	typedef struct packed
	{
		lmc_state_t          st;      // controller state
		lmc_mode_t           mode;    // believed device mode
		logic                en;      // enable pin
		logic                txd;     // transmit pin
		logic [DATA_W:0]     shift;   // stop bit and data, lsb first
		logic [3:0]          bits;    // bits still to send
		logic [BAUD_W-1:0]   baud;    // bit-time divider
		logic [DOM_W-1:0]    dom;     // cycles txd has been low
		logic [GUARD_W-1:0]  guard;   // forced-high cycles left
		logic [SETUP_W-1:0]  setup;   // mode select window count
		logic                lvl;     // txd level for the enable fall
		logic                wake;    // remote wake-up seen
		logic                rx;      // registered rxd
		logic                in_reset;  // registered reset pin
		logic                busy;    // byte on the wire
	} host_st_t;

	host_st_t              s;          // current state
	host_st_t              next_s;     // next state
	logic                  rst_meta;   // reset release stage one
	logic                  rst_sync;   // reset used by the design
	logic                  tick;       // one-cycle bit enable
	logic                  pop;        // take a byte from the fifo
	logic [DATA_W-1:0]     f_data;     // head byte
	logic                  f_valid;    // head byte present
	logic                  data_lvl;   // txd before the guard

	////////////////////////////////////////////////////////////////////////
	// reset released through two flip-flops
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// byte buffer; a full fifo holds tx_ready low
	lmc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_sync),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (pop)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs taken from the state
	assign pins    = '{enable: s.en, txd: s.txd};
	assign status  = '{mode: s.mode, in_reset: s.in_reset, wake: s.wake,
		rx_bit: s.rx};
	assign tx_busy = s.busy;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_s   = s;
		pop      = 1'b0;
		tick     = 1'b0;
		data_lvl = s.lvl;
		// bit-rate divider, free running
		if (s.baud == BAUD_W'(BIT_CYC - 1))
		begin
			next_s.baud = '0;
			tick        = 1'b1;
		end
		else
			next_s.baud = s.baud + BAUD_W'(1);
		next_s.rx       = rxd;
		next_s.in_reset = !undervoltage_reset_n;

		if (!undervoltage_reset_n)
		begin
			next_s.st    = LMC_ST_FAILSAFE;
			next_s.mode  = LMC_MODE_FAILSAFE;
			next_s.en    = 1'b0;
			next_s.bits  = '0;
			next_s.busy  = 1'b0;
			data_lvl     = 1'b1;
		end
		else
		begin
			case (s.st)
				// fail-safe: wait for a normal request
				LMC_ST_FAILSAFE:
				begin
					data_lvl = 1'b1;
					if (!s.rx)
						next_s.wake = 1'b1;
					if (mode_req && mode_sel == LMC_MODE_NORMAL)
					begin
						next_s.en   = 1'b1;
						next_s.st   = LMC_ST_NORMAL;
						next_s.mode = LMC_MODE_NORMAL;
						next_s.wake = 1'b0;
					end
				end
				// normal: serialise bytes, accept low-power requests
				LMC_ST_NORMAL:
				begin
					data_lvl = 1'b1;
					if (s.bits != '0)
					begin
						data_lvl = s.txd;
						if (tick)
						begin
							data_lvl     = s.shift[0];
							next_s.shift = {1'b1, s.shift[DATA_W:1]};
							next_s.bits  = s.bits - 4'h1;
						end
					end
					else if (mode_req && (mode_sel == LMC_MODE_SILENT ||
						mode_sel == LMC_MODE_SLEEP))
					begin
						next_s.lvl   = (mode_sel == LMC_MODE_SILENT);
						next_s.setup = '0;
						next_s.st    = LMC_ST_SETUP;
						next_s.busy  = 1'b0;
					end
					else if (tick && f_valid)
					begin
						// start bit goes out now
						pop          = 1'b1;
						data_lvl     = 1'b0;
						next_s.shift = {1'b1, f_data};
						next_s.bits  = 4'(FRAME_BITS);
						next_s.busy  = 1'b1;
					end
					else if (tick)
						next_s.busy = 1'b0;
				end
				// hold the select level, then drop enable
				LMC_ST_SETUP:
				begin
					data_lvl = s.lvl;
					if (s.setup == SETUP_W'(SETUP_CYC - 1))
					begin
						next_s.en   = 1'b0;
						next_s.st   = LMC_ST_LOWPWR;
						next_s.mode = s.lvl ? LMC_MODE_SILENT : LMC_MODE_SLEEP;
					end
					else
						next_s.setup = s.setup + SETUP_W'(1);
				end
				// silent or sleep: watch for wake, allow normal
				LMC_ST_LOWPWR:
				begin
					data_lvl = 1'b1;
					if (!s.rx)
					begin
						next_s.wake = 1'b1;
						next_s.st   = LMC_ST_FAILSAFE;
						next_s.mode = LMC_MODE_FAILSAFE;
					end
					if (mode_req && mode_sel == LMC_MODE_NORMAL)
					begin
						next_s.en   = 1'b1;
						next_s.st   = LMC_ST_NORMAL;
						next_s.mode = LMC_MODE_NORMAL;
					end
				end
				default:
					next_s.st = LMC_ST_FAILSAFE;
			endcase
		end

		if (s.guard != '0)
		begin
			next_s.guard = s.guard - GUARD_W'(1);
			next_s.txd   = 1'b1;
		end
		else if (!s.txd && s.dom >= DOM_W'(DOM_LIMIT - 1))
		begin
			next_s.guard = GUARD_W'(RECOVER_CYC - 1);
			next_s.txd   = 1'b1;
		end
		else
			next_s.txd = data_lvl;
		// low-time counter follows the pin itself
		next_s.dom = s.txd ? '0 : s.dom + DOM_W'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// state register; txd idles high so the bus stays recessive
	always_ff @(posedge ref_clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			s     <= '0;
			s.txd <= 1'b1;
			s.rx  <= 1'b1;
			s.lvl <= 1'b1;
		end
		else
			s <= next_s;
	end

endmodule

/* File: lmc_host_chk.sv */
// assertions on the mode controller's ports
`timescale 1ns/1ps
module lmc_host_chk
	import lmc_pkg::*;
#(
	parameter int DOM_LIMIT = DOM_CYC
)
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// user side
	input wire logic        mode_req,
	input wire lmc_mode_t   mode_sel,
	input wire lmc_status_t status,
	input wire logic        tx_busy,
	// transceiver pins
	input wire lmc_pins_t   pins,
	input wire logic        rxd,
	input wire logic        undervoltage_reset_n
);
	logic [2:0]  rel;   // covers the two-flop reset release
	logic [17:0] low;   // cycles txd has stayed low
	logic [7:0]  since; // cycles since the last mode request

	////////////////////////////////////////////////////////////////////////
	// helper counters
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			rel   <= 3'h0;
			low   <= 18'h0;
			since <= 8'h0;
		end
		else
		begin
			rel   <= {rel[1:0], 1'b1};
			low   <= pins.txd ? 18'h0 : low + 18'h1;
			since <= mode_req ? 8'h0 : since + 8'(since != 8'hff);
		end

	default clocking cb @(posedge ref_clk); endclocking
	// internal reset lags the port, so wait for it
	default disable iff (!rel[2]);

	////////////////////////////////////////////////////////////////////////
	// reset pin forces idle pins
	a_reset_idle:
	assert property (!undervoltage_reset_n [*3] |-> !pins.enable && pins.txd)
		else $error("pins not idle while reset pin low");
	// reset pin seen one cycle later
	a_reset_seen:
	assert property (1'b1 |=> status.in_reset == !$past(undervoltage_reset_n))
		else $error("in_reset does not follow reset pin");
	a_rx_follow:
	assert property (1'b1 |=> status.rx_bit == $past(rxd))
		else $error("rx_bit does not follow rxd");
	a_normal_ans:
	assert property (mode_req && mode_sel == LMC_MODE_NORMAL &&
		undervoltage_reset_n && status.mode != LMC_MODE_NORMAL
		|=> pins.enable && status.mode == LMC_MODE_NORMAL)
		else $error("normal request not answered");
	a_silent_lvl:
	assert property (mode_req && mode_sel == LMC_MODE_SILENT &&
		undervoltage_reset_n && status.mode == LMC_MODE_NORMAL &&
		!tx_busy && since > 8'hd2 |=> pins.txd && pins.enable)
		else $error("silent request level wrong");
	// sleep request lowers txd first
	// txd follows one cycle after the setup state is entered
	a_sleep_lvl:
	assert property (mode_req && mode_sel == LMC_MODE_SLEEP &&
		undervoltage_reset_n && status.mode == LMC_MODE_NORMAL &&
		!tx_busy && since > 8'hd2 |=> pins.enable ##1
		(!pins.txd && pins.enable))
		else $error("sleep request level wrong");
	// mode follows txd at enable fall
	a_fall_mode:
	assert property ($fell(pins.enable) && undervoltage_reset_n &&
		$past(undervoltage_reset_n) |-> status.mode ==
		(pins.txd ? LMC_MODE_SILENT : LMC_MODE_SLEEP))
		else $error("mode does not match txd at enable fall");
	// host never holds txd low past the limit
	a_dom_limit:
	assert property (low <= DOM_LIMIT)
		else $error("txd low too long");
	// wake from silent in two cycles
	a_wake_fs:
	assert property (status.mode == LMC_MODE_SILENT && !rxd &&
		undervoltage_reset_n |-> ##2 status.mode == LMC_MODE_FAILSAFE &&
		status.wake)
		else $error("wake not taken");
	// frame opens with a dominant start bit
	a_start_bit:
	assert property ($rose(tx_busy) |-> !pins.txd)
		else $error("frame without start bit");
endmodule

/* File: lmc_xcvr_model.sv */
// behavioural transceiver at the controller's pins
`timescale 1ns/1ps
module lmc_xcvr_model
	import lmc_pkg::*;
#(
	parameter int HOLD_CYC = 80000,  // reset hold, 4 ms
	parameter int WAKE_CYC = 1800,   // 90 us of dominant bus
	parameter int TDOM_CYC = 120000, // dominant timeout
	parameter int TREC_CYC = 201     // high time re-arming the driver
)
(
	// clock
	input  wire logic       clk,
	// supply and far bus
	input  wire logic [1:0] vs_level,   // 0 off, 1 below 5V, 2 good
	input  wire logic       remote_dom, // other node pulls bus low
	// host pins
	input  wire lmc_pins_t  pins,
	output logic            rxd,
	output logic            undervoltage_reset_n
);
	lmc_mode_t mode   = LMC_MODE_FAILSAFE;
	logic      en_q   = 1'b0;
	logic      wake   = 1'b0;
	logic      drv_ok = 1'b1;
	logic      tog    = 1'b0; // unpowered pins wander
	int        hold   = 0;
	int        dom    = 0;
	int        hi     = 0;
	int        bus_lo = 0;
	// own driver only when powered and armed
	wire bus_dom = remote_dom | (mode == LMC_MODE_NORMAL && !pins.txd &&
		drv_ok && vs_level == 2'h2);

	// one mode machine with its counters
	always @(posedge clk)
	begin
		tog    <= !tog;
		en_q   <= pins.enable;
		dom    <= pins.txd ? 0 : dom + 1;
		hi     <= pins.txd ? hi + 1 : 0;
		bus_lo <= bus_dom ? bus_lo + 1 : 0;
		if (dom > TDOM_CYC)
			drv_ok <= 1'b0;
		else if (hi > TREC_CYC)
			drv_ok <= 1'b1;
		if (vs_level == 2'h0)
		begin
			mode <= LMC_MODE_FAILSAFE;
			hold <= 0;
			wake <= 1'b0;
		end
		// wake after long dominant then a rise
		else if (mode == LMC_MODE_SLEEP || mode == LMC_MODE_SILENT)
		begin
			if (bus_lo >= WAKE_CYC && !bus_dom)
			begin
				wake <= 1'b1;
				mode <= LMC_MODE_FAILSAFE;
				if (mode == LMC_MODE_SLEEP)
					hold <= 0;
			end
		end
		else if (hold < HOLD_CYC)
		begin
			hold <= hold + 1;
			mode <= LMC_MODE_FAILSAFE;
		end
		else if (pins.enable)
		begin
			mode <= LMC_MODE_NORMAL;
			wake <= 1'b0;
		end
		else if (en_q && mode == LMC_MODE_NORMAL)
			mode <= pins.txd ? LMC_MODE_SILENT : LMC_MODE_SLEEP;
	end

	assign rxd = (vs_level == 2'h0) ? tog :
		(mode == LMC_MODE_SLEEP || wake) ? 1'b0 :
		(mode == LMC_MODE_NORMAL) ? !bus_dom : 1'b1;
	// reset pin, low while regulator off
	assign undervoltage_reset_n = (vs_level == 2'h0) ? !tog :
		(mode != LMC_MODE_SLEEP && hold >= HOLD_CYC);
endmodule

/* File: tb_lmc_host.sv */
// self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
module tb_lmc_host
	import lmc_pkg::*;
;
	localparam int BITS = 10;  // short bit time
	localparam int HOLD = 400; // short reset hold
	logic              ref_clk  = 1'b0;
	logic              reset_n  = 1'b0;
	logic [DATA_W-1:0] tx_data  = 8'h00;
	logic              tx_valid = 1'b0;
	logic              mode_req = 1'b0;
	logic              remote_dom = 1'b0;
	logic [1:0]        vs_level = 2'h0;
	lmc_mode_t         mode_sel = LMC_MODE_FAILSAFE;
	logic              tx_ready, tx_busy, rxd, undervoltage_reset_n;
	lmc_status_t       status;
	lmc_pins_t         pins;
	int                mismatches = 0;
	int                n_compared = 0;

	lmc_host #(.DOM_LIMIT(300), .BIT_CYC(BITS)) dut (.ref_clk(ref_clk),
		.reset_n(reset_n), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .mode_req(mode_req), .mode_sel(mode_sel),
		.status(status), .tx_busy(tx_busy), .pins(pins), .rxd(rxd),
		.undervoltage_reset_n(undervoltage_reset_n));
	lmc_xcvr_model #(.HOLD_CYC(HOLD), .TDOM_CYC(320)) xcvr (.clk(ref_clk),
		.vs_level(vs_level), .remote_dom(remote_dom), .pins(pins),
		.rxd(rxd), .undervoltage_reset_n(undervoltage_reset_n));

	initial
		forever #25 ref_clk = ~ref_clk;

	task automatic results();
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, got);
		n_compared++;
		if (exp !== got)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic request(input lmc_mode_t sel);
		@(posedge ref_clk);
		mode_req <= 1'b1;
		mode_sel <= sel;
		@(posedge ref_clk);
		mode_req <= 1'b0;
		#1;
	endtask

	// remote node holds the bus dominant past the wake time
	task automatic remote_wake();
		@(posedge ref_clk);
		remote_dom <= 1'b1;
		cyc(1700);
		check("early wake", 2'(LMC_MODE_SILENT), status.mode);
		cyc(150);
		remote_dom <= 1'b0;
	endtask

	task automatic t_start();
		cyc(3);
		check("idle pins", 2'h1, pins);
		request(LMC_MODE_NORMAL);
		check("enable in hold", 1'b0, pins.enable);
		for (int i = 0; i < HOLD && status.in_reset; i++)
			@(posedge ref_clk);
		check("hold over", 1'b0, status.in_reset);
		request(LMC_MODE_NORMAL);
		check("normal pins", 2'h3, pins);
	endtask

	// one byte; rx_bit shows the byte only when the supply is good
	task automatic t_frame(input logic [7:0] d, input logic good);
		logic [9:0] f;
		logic [9:0] r;
		@(posedge ref_clk);
		tx_data  <= d;
		tx_valid <= 1'b1;
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		for (int i = 0; i < 50 && pins.txd; i++)
			@(posedge ref_clk);
		cyc(BITS / 2 - 1);
		for (int k = 0; k < 10; k++)
		begin
			f[k] = pins.txd;
			r[k] = status.rx_bit;
			cyc(BITS);
		end
		check("frame", {1'b1, d, 1'b0}, f);
		check("rx", good ? {1'b1, d, 1'b0} : 10'h3ff, r);
	endtask

	task automatic t_fifo();
		int n;
		n = 0;
		@(posedge ref_clk);
		tx_valid <= 1'b1;
		for (int i = 0; i < 20 && tx_ready; i++)
		begin
			@(posedge ref_clk);
			n += int'(tx_ready);
		end
		tx_valid <= 1'b0;
		check("refused", 1'b0, tx_ready);
		check("taken", 1'b1, n == 8 || n == 9);
		for (int i = 0; i < 2000 && tx_busy; i++)
			@(posedge ref_clk);
		cyc(2);
		// idle again: not busy, room in the fifo, normal pins recessive
		check("drained", 4'h7, {tx_busy, tx_ready, pins});
	endtask

	task automatic t_silent();
		request(LMC_MODE_SILENT);
		cyc(205);
		check("silent", 4'h9, {status.mode, pins});
		remote_wake();
		cyc(4);
		check("wake", 3'h1, {status.mode, status.wake});
		request(LMC_MODE_NORMAL);
		cyc(220);
	endtask

	task automatic t_sleep();
		request(LMC_MODE_SLEEP);
		cyc(205);
		// sleep drops the regulator, so reset pulls the host to fail-safe
		check("sleep", 5'h11, {status.in_reset, status.mode, pins});
		@(posedge ref_clk);
		remote_dom <= 1'b1;
		cyc(1850);
		remote_dom <= 1'b0;
		for (int i = 0; i < HOLD + 50 && !status.in_reset; i++)
			@(posedge ref_clk);
		for (int i = 0; i < HOLD + 50 && status.in_reset; i++)
			@(posedge ref_clk);
		cyc(4);
		check("sleep wake", 1'b1, status.wake);
	endtask

	initial
	begin
		cyc(2);
		vs_level <= 2'h2;
		cyc(8);
		reset_n <= 1'b1;
		t_start();
		t_frame(8'ha5, 1'b1);
		t_fifo();
		vs_level <= 2'h1;
		t_frame(8'h00, 1'b0);
		vs_level <= 2'h2;
		cyc(220);
		t_silent();
		t_sleep();
		results();
	end

	initial
	begin
		cyc(20000);
		mismatches++;
		results();
	end
endmodule

bind lmc_host lmc_host_chk #(.DOM_LIMIT(DOM_LIMIT)) chk (.ref_clk(ref_clk),
	.reset_n(reset_n), .mode_req(mode_req), .mode_sel(mode_sel),
	.status(status), .tx_busy(tx_busy), .pins(pins), .rxd(rxd),
	.undervoltage_reset_n(undervoltage_reset_n));
